// ---- design/boundary_scan_test_operations.sv ----
`timescale 1ns/1ps
`include "bst_defs.svh"

// Test-operation logic of an octal boundary-scan buffer. The test access port state
// machine and instruction register sit outside; this block sees the current
// instruction and the state levels, all on the test clock. A small status view is
// carried across into the system clock domain.
module boundary_scan_test_operations (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       tck,
  input  wire logic       tap_reset,
  input  wire logic [7:0] ir_code,
  input  wire logic       capture_dr,
  input  wire logic       shift_dr,
  input  wire logic       update_dr,
  input  wire logic       run_idle,
  input  wire logic       tdi,
  output logic            tdo,
  output logic            tdo_oe,
  input  wire logic [7:0] pin_in,
  input  wire logic [1:0] pin_oe_n,
  input  wire logic [7:0] core_y,
  output logic      [7:0] core_a,
  output logic      [7:0] pin_y,
  output logic      [7:0] pin_y_oe,
  output logic            sys_test_mode,
  output logic            sys_run_active,
  output logic      [1:0] sys_op
);

  // 16-bit pattern step; no constant term, so zero maps to zero.
  function automatic logic [15:0] lfsr16(input logic [15:0] s);
    logic fb;
    fb = s[15] ^ s[13] ^ s[12] ^ s[10];
    return {s[14:0], fb};
  endfunction

  // 8-bit pattern step, used for both halves of the combined mode.
  function automatic logic [7:0] lfsr8(input logic [7:0] s);
    logic fb;
    fb = s[7] ^ s[5] ^ s[4] ^ s[3];
    return {s[6:0], fb};
  endfunction

  // Instruction decode.
  logic [6:0] ir_op;
  logic       ins_run;
  logic       ins_read_n;
  logic       ins_read_t;
  logic       ins_self;
  logic       ins_toggle;
  logic       ins_ctrl_n;
  logic       ins_ctrl_t;
  logic       test_mode;
  bst_pkg::scan_path_t path;

  assign ir_op      = ir_code[6:0];
  assign ins_run    = (ir_op == `BST_IR_RUN_SELECTED);
  assign ins_read_n = (ir_op == `BST_IR_READ_NORMAL);
  assign ins_read_t = (ir_op == `BST_IR_READ_TESTMODE);
  assign ins_self   = (ir_op == `BST_IR_SELF_CHECK);
  assign ins_toggle = (ir_op == `BST_IR_OUTPUT_TOGGLE);
  assign ins_ctrl_n = (ir_op == `BST_IR_CTRL_NORMAL);
  assign ins_ctrl_t = (ir_op == `BST_IR_CTRL_TESTMODE);

  // Self check runs in normal mode so the pins keep their buffer function.
  assign test_mode = ins_run | ins_read_t | ins_toggle | ins_ctrl_t;

  // Path select; unknown codes fall back to the bypass register.
  always_comb begin
    if (ins_read_n || ins_read_t || ins_self) begin
      path = bst_pkg::PATH_CHAIN;
    end else if (ins_ctrl_n || ins_ctrl_t) begin
      path = bst_pkg::PATH_CTRL;
    end else begin
      path = bst_pkg::PATH_BYPASS;
    end
  end

  // Functional pins cross into the test clock through two flops before use.
  logic [9:0] pins_s;
  logic [7:0] pin_in_s;
  logic [1:0] pin_oe_n_s;

  level_sync #(
    .W (10)
  ) u_pin_sync (
    .clk   (tck),
    .rst_n (~tap_reset),
    .d     ({pin_oe_n, pin_in}),
    .q     (pins_s)
  );

  assign pin_in_s   = pins_s[7:0];
  assign pin_oe_n_s = pins_s[9:8];

  // Test control register.
  bst_pkg::test_op_t op;
  logic              tcr_lsb;
  logic              ctrl_sel;

  assign ctrl_sel = (path == bst_pkg::PATH_CTRL);

  test_control_reg u_tcr (
    .tck       (tck),
    .tap_reset (tap_reset),
    .selected  (ctrl_sel),
    .shift_dr  (shift_dr),
    .update_dr (update_dr),
    .tdi       (tdi),
    .shift_lsb (tcr_lsb),
    .op        (op)
  );

  // Running flags for the two free-running instructions.
  logic run_go;
  logic toggle_go;

  assign run_go    = ins_run & run_idle;
  assign toggle_go = ins_toggle & run_idle;

  // Bypass register: captures zero, then shifts.
  logic bypass_reg;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bypass_reg <= 1'b0;
    end else if (path == bst_pkg::PATH_BYPASS) begin
      if (capture_dr) begin
        bypass_reg <= 1'b0;
      end else if (shift_dr) begin
        bypass_reg <= tdi;
      end
    end
  end

  // Shift stages of the boundary cells, all moved on the rising test clock.
  logic [`BST_CHAIN_W-1:0] chain_reg;
  logic [`BST_CHAIN_W-1:0] chain_next;
  logic [15:0]             data_cells;

  assign data_cells = chain_reg[`BST_IN_HI:`BST_OUT_LO];

  // The enable cells are carried through every run algorithm untouched; self check inverts them with the rest.
  always_comb begin
    chain_next = chain_reg;
    if (path == bst_pkg::PATH_CHAIN) begin
      if (capture_dr) begin
        if (ins_self) begin
          chain_next = ~chain_reg;
        end else begin
          chain_next = chain_reg;
        end
      end else if (shift_dr) begin
        chain_next = {tdi, chain_reg[`BST_CHAIN_W-1:1]};
      end
    end else if (toggle_go) begin
      chain_next[`BST_OUT_HI:`BST_OUT_LO] = ~chain_reg[`BST_OUT_HI:`BST_OUT_LO];
      chain_next[`BST_IN_HI:`BST_IN_LO]   = chain_reg[`BST_IN_HI:`BST_IN_LO];
    end else if (run_go) begin
      case (op)
        bst_pkg::OP_SAMPLE_TOGGLE: begin
          chain_next[`BST_IN_HI:`BST_IN_LO]   = pin_in_s;
          chain_next[`BST_OUT_HI:`BST_OUT_LO] = ~chain_reg[`BST_OUT_HI:`BST_OUT_LO];
        end
        bst_pkg::OP_PATTERN16: begin
          chain_next[`BST_IN_HI:`BST_OUT_LO] = lfsr16(data_cells);
        end
        bst_pkg::OP_SIGNATURE16: begin
          chain_next[`BST_IN_HI:`BST_OUT_LO] = lfsr16(data_cells) ^ {pin_in_s, 8'h00};
        end
        bst_pkg::OP_COMBINED8: begin
          chain_next[`BST_IN_HI:`BST_IN_LO] =
            lfsr8(chain_reg[`BST_IN_HI:`BST_IN_LO]) ^ pin_in_s;
          chain_next[`BST_OUT_HI:`BST_OUT_LO] =
            lfsr8(chain_reg[`BST_OUT_HI:`BST_OUT_LO]);
        end
        default: begin
          chain_next = chain_reg;
        end
      endcase
    end
  end

  // Inputs and instruction levels are taken on the rising edge.
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  // Shadow latches. They move only on the falling edge so pins and core inputs
  // never change in the same half cycle that the shift stages are sampled.
  logic [7:0] out_shadow_reg;
  logic [7:0] in_shadow_reg;
  logic [1:0] oe_shadow_reg;
  logic       load_out;
  logic       load_in;

  // Which latch groups follow their shift stages during a run.
  always_comb begin
    load_out = 1'b0;
    load_in  = 1'b0;
    if (toggle_go) begin
      load_out = 1'b1;
      load_in  = 1'b0;
    end else if (run_go) begin
      case (op)
        bst_pkg::OP_SAMPLE_TOGGLE: begin
          load_out = 1'b1;
          load_in  = 1'b1;
        end
        bst_pkg::OP_PATTERN16: begin
          load_out = 1'b1;
          load_in  = 1'b1;
        end
        bst_pkg::OP_SIGNATURE16: begin
          load_out = 1'b0;
          load_in  = 1'b1;
        end
        bst_pkg::OP_COMBINED8: begin
          load_out = 1'b1;
          load_in  = 1'b1;
        end
        default: begin
          load_out = 1'b0;
          load_in  = 1'b0;
        end
      endcase
    end
  end

  // A step is applied on the falling edge after it, so a run's last step still reaches the pins.
  logic load_out_reg;
  logic load_in_reg;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      load_out_reg <= 1'b0;
      load_in_reg  <= 1'b0;
    end else begin
      load_out_reg <= load_out;
      load_in_reg  <= load_in;
    end
  end

  // Output data latches.
  always_ff @(negedge tck) begin
    if (tap_reset) begin
      out_shadow_reg <= 8'h00;
    end else if (path == bst_pkg::PATH_CHAIN && update_dr) begin
      out_shadow_reg <= chain_reg[`BST_OUT_HI:`BST_OUT_LO];
    end else if (load_out_reg) begin
      out_shadow_reg <= chain_reg[`BST_OUT_HI:`BST_OUT_LO];
    end
  end

  // Input data latches.
  always_ff @(negedge tck) begin
    if (tap_reset) begin
      in_shadow_reg <= 8'h00;
    end else if (path == bst_pkg::PATH_CHAIN && update_dr) begin
      in_shadow_reg <= chain_reg[`BST_IN_HI:`BST_IN_LO];
    end else if (load_in_reg) begin
      in_shadow_reg <= chain_reg[`BST_IN_HI:`BST_IN_LO];
    end
  end

  // Enable latches load only from a scan update, never from a run.
  always_ff @(negedge tck) begin
    if (tap_reset) begin
      oe_shadow_reg <= 2'h3;
    end else if (path == bst_pkg::PATH_CHAIN && update_dr) begin
      oe_shadow_reg <= chain_reg[`BST_OE_HI:`BST_OE_LO];
    end
  end

  // Serial output, driven only while shifting, changed on the falling edge.
  logic scan_out;

  always_comb begin
    case (path)
      bst_pkg::PATH_CHAIN: begin
        scan_out = chain_reg[0];
      end
      bst_pkg::PATH_CTRL: begin
        scan_out = tcr_lsb;
      end
      default: begin
        scan_out = bypass_reg;
      end
    endcase
  end

  always_ff @(negedge tck) begin
    if (tap_reset) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= scan_out;
      tdo_oe <= shift_dr;
    end
  end

  // Pin multiplexing. Each active-low enable gates one nibble of outputs: the enable cell in test mode,
  // the pin_oe_n input in normal mode; runs count as test mode, so the enable cells hold the enables while the data cells run.
  logic [1:0] oe_n_sel;

  assign oe_n_sel = test_mode ? oe_shadow_reg : pin_oe_n_s;
  assign pin_y    = test_mode ? out_shadow_reg : core_y;
  assign core_a   = test_mode ? in_shadow_reg : pin_in_s;
  assign pin_y_oe = {{4{~oe_n_sel[1]}}, {4{~oe_n_sel[0]}}};

  // Status view for the system side. The word is launched from a register, so no
  // decode glitch is ever synchronised, and filtered so the op bits never tear.
  logic [3:0] status_tck_reg;
  logic [3:0] status_sys;
  logic [3:0] status_prev_reg;
  logic [3:0] status_reg;

  // Launch register of the crossing, on the test clock.
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      status_tck_reg <= {`BST_TCR_RESET, 2'h0};
    end else begin
      status_tck_reg <= {op, run_go | toggle_go, test_mode};
    end
  end

  level_sync #(
    .W (4)
  ) u_status_sync (
    .clk   (clk_sys),
    .rst_n (reset_n),
    .d     (status_tck_reg),
    .q     (status_sys)
  );

  // Previous synchronised word. A word is taken only once it reads alike on two
  // edges; the cost is one more clk_sys cycle of latency on a slow status view.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_prev_reg <= 4'h0;
    end else begin
      status_prev_reg <= status_sys;
    end
  end

  // Accepted status word, driving the system-side outputs.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_reg <= 4'h0;
    end else if (status_sys == status_prev_reg) begin
      status_reg <= status_sys;
    end
  end

  assign sys_test_mode  = status_reg[0];
  assign sys_run_active = status_reg[1];
  assign sys_op         = status_reg[3:2];

endmodule // boundary_scan_test_operations

// ---- design/bst_defs.svh ----
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// Instruction codes, bit 7 ignored.
`define BST_IR_RUN_SELECTED   7'h09
`define BST_IR_READ_NORMAL    7'h0A
`define BST_IR_READ_TESTMODE  7'h0B
`define BST_IR_SELF_CHECK     7'h0C
`define BST_IR_OUTPUT_TOGGLE  7'h0D
`define BST_IR_CTRL_NORMAL    7'h0E
`define BST_IR_CTRL_TESTMODE  7'h0F

// Control register operation codes and reset value.
`define BST_OP_SAMPLE_TOGGLE  2'h0
`define BST_OP_PATTERN16      2'h1
`define BST_OP_SIGNATURE16    2'h2
`define BST_OP_COMBINED8      2'h3
`define BST_TCR_RESET         2'h2

// Chain field positions: enables, input cells, output cells.
`define BST_CHAIN_W           18
`define BST_OE_HI             17
`define BST_OE_LO             16
`define BST_IN_HI             15
`define BST_IN_LO             8
`define BST_OUT_HI            7
`define BST_OUT_LO            0

// Synchroniser depth.
`define BST_SYNC_STAGES       2

`endif

// ---- design/bst_pkg.sv ----
`include "bst_defs.svh"

package bst_pkg;

  // Operation selected by the control register.
  typedef enum logic [1:0] {
    OP_SAMPLE_TOGGLE = `BST_OP_SAMPLE_TOGGLE,
    OP_PATTERN16     = `BST_OP_PATTERN16,
    OP_SIGNATURE16   = `BST_OP_SIGNATURE16,
    OP_COMBINED8     = `BST_OP_COMBINED8
  } test_op_t;

  // Data register in the scan path, one-hot.
  typedef enum logic [2:0] {
    PATH_BYPASS = 3'h1,
    PATH_CHAIN  = 3'h2,
    PATH_CTRL   = 3'h4
  } scan_path_t;

endpackage

// ---- design/level_sync.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser for quasi-static levels.
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // level_sync

// ---- design/test_control_reg.sv ----
`timescale 1ns/1ps
`include "bst_defs.svh"

// Two-bit test control register with shift and update stages.
module test_control_reg (
  input  wire logic       tck,
  input  wire logic       tap_reset,
  input  wire logic       selected,
  input  wire logic       shift_dr,
  input  wire logic       update_dr,
  input  wire logic       tdi,
  output logic            shift_lsb,
  output bst_pkg::test_op_t op
);

  logic [1:0] shift_reg;

  // Capture-DR leaves the shift stage alone, so the old value scans back out.
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      shift_reg <= `BST_TCR_RESET;
    end else if (selected && shift_dr) begin
      shift_reg <= {tdi, shift_reg[1]};
    end
  end

  // Update stage moves on the falling edge, like the shadow latches and tdo; shift_lsb follows the rising edge.
  always_ff @(negedge tck) begin
    if (tap_reset) begin
      op <= bst_pkg::OP_SIGNATURE16;
    end else if (selected && update_dr) begin
      op <= bst_pkg::test_op_t'(shift_reg);
    end
  end

  assign shift_lsb = shift_reg[0];

endmodule // test_control_reg

// ---- bench/bsto_sva.sv ----
`timescale 1ns/1ps

// Port-level checks of the test-operation block.
module bsto_sva (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       tck,
  input wire logic       tap_reset,
  input wire logic [7:0] ir_code,
  input wire logic       capture_dr,
  input wire logic       shift_dr,
  input wire logic       run_idle,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  input wire logic [7:0] core_y,
  input wire logic [7:0] core_a,
  input wire logic [7:0] pin_y,
  input wire logic [7:0] pin_y_oe,
  input wire logic       sys_test_mode,
  input wire logic       sys_run_active
);
  logic byp;
  logic tog;
  logic runs;

  // Run instructions put the one-bit bypass stage in the path; bit 7 is ignored.
  assign byp  = ir_code[6:0] == 7'h09 || ir_code[6:0] == 7'h0D;
  assign tog  = ir_code[6:0] == 7'h0D;
  assign runs = run_idle && byp;

  a_bypass_zero: assert property (@(posedge tck) disable iff (tap_reset)
    capture_dr && byp ##1 shift_dr |-> !tdo) else $error("bypass stage did not capture zero");
  a_drive_on: assert property (@(posedge tck) disable iff (tap_reset)
    $rose(shift_dr) |-> tdo_oe) else $error("serial out not driven in shift");
  a_drive_off: assert property (@(posedge tck) disable iff (tap_reset)
    $fell(shift_dr) |-> !tdo_oe) else $error("serial out still driven after shift");
  a_toggle_out: assert property (@(posedge tck) disable iff (tap_reset)
    runs && tog && $past(runs && tog) |-> pin_y == ~$past(pin_y)) else $error("outputs did not toggle");
  a_toggle_in_hold: assert property (@(posedge tck) disable iff (tap_reset)
    runs && tog && $past(runs && tog) |-> $stable(core_a)) else $error("core inputs moved in toggle");
  a_enable_hold: assert property (@(posedge tck) disable iff (tap_reset)
    runs && $past(runs) |-> $stable(pin_y_oe)) else $error("output enables moved in a run");
  a_check_normal: assert property (@(posedge tck) disable iff (tap_reset)
    ir_code[6:0] == 7'h0C && $past(ir_code[6:0]) == 7'h0C |-> pin_y == core_y)
    else $error("self check left normal mode");
  a_run_in_test: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sys_run_active |-> sys_test_mode) else $error("run reported outside test mode");
endmodule // bsto_sva

bind boundary_scan_test_operations bsto_sva u_bsto_sva (
  .clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tap_reset(tap_reset), .ir_code(ir_code),
  .capture_dr(capture_dr), .shift_dr(shift_dr), .run_idle(run_idle), .tdo(tdo), .tdo_oe(tdo_oe),
  .core_y(core_y), .core_a(core_a), .pin_y(pin_y), .pin_y_oe(pin_y_oe),
  .sys_test_mode(sys_test_mode), .sys_run_active(sys_run_active)
);

// ---- bench/scan_host.sv ----
`timescale 1ns/1ps

// Test controller model. State levels change just after a rising test clock, as a real
// state machine would; serial data changes on the falling edge.
module scan_host (
  input  wire logic       tck,
  input  wire logic       tdo,
  output logic            tap_reset,
  output logic      [7:0] ir_code,
  output logic            capture_dr,
  output logic            shift_dr,
  output logic            update_dr,
  output logic            run_idle,
  output logic            tdi
);
  logic shifting;

  // Outside shifts the data line means nothing, so it keeps moving rather than lingering.
  initial begin
    {tap_reset, ir_code, capture_dr, shift_dr, update_dr, run_idle, tdi, shifting} = {1'b1, 8'h01, 6'h00};
  end
  always @(negedge tck) begin
    if (!shifting)
      tdi <= ~tdi;
  end

  task automatic reset_tap();
    @(posedge tck);
    tap_reset <= 1'b1;
    repeat (3) @(posedge tck);
    tap_reset <= 1'b0;
  endtask

  // Capture, n shifts least significant bit first, then update.
  task automatic scan(input logic [7:0] ir, input int n, input logic [17:0] din, output logic [17:0] dout);
    @(posedge tck);
    ir_code <= ir;
    @(posedge tck);
    capture_dr <= 1'b1;
    @(posedge tck);
    capture_dr <= 1'b0;
    shift_dr <= 1'b1;
    shifting = 1'b1;
    dout = 18'h00000;
    for (int i = 0; i < n; i++) begin
      @(negedge tck);
      tdi <= din[i];
      @(posedge tck);
      dout[i] = tdo;
    end
    shifting = 1'b0;
    shift_dr <= 1'b0;
    update_dr <= 1'b1;
    @(posedge tck);
    update_dr <= 1'b0;
    @(posedge tck);
  endtask

  // Stays in Run-Test/Idle for n rising edges, then lets the last update land.
  task automatic run(input logic [7:0] ir, input int n);
    @(posedge tck);
    ir_code <= ir;
    @(posedge tck);
    run_idle <= 1'b1;
    repeat (n) @(posedge tck);
    run_idle <= 1'b0;
    @(negedge tck);
    @(posedge tck);
  endtask
endmodule // scan_host

// ---- bench/boundary_scan_test_operations_tb.sv ----
`timescale 1ns/1ps

module boundary_scan_test_operations_tb;
  `define CHK(nm, x, y) begin samples_checked++; if ((y) !== (x)) begin mismatches++; \
    $display("BAD %s expected %h seen %h", nm, x, y); end end

  typedef struct {logic [7:0] ir; logic [1:0] op; logic [17:0] seed; logic [7:0] pins; int n;} row_t;

  logic        clk_sys, reset_n, tck, tap_reset, capture_dr, shift_dr, update_dr, run_idle, tdi, tdo;
  logic        tdo_oe, sys_test_mode, sys_run_active;
  logic [1:0]  pin_oe_n, sys_op;
  logic [7:0]  ir_code, pin_in, core_y, core_a, pin_y, pin_y_oe;
  logic [17:0] d, want;
  int          mismatches, samples_checked;
  row_t        rows [7] = '{'{8'h09, 2'h0, 18'h1A5C3, 8'h3C, 3}, '{8'h09, 2'h1, 18'h2BEEF, 8'h5A, 4},
    '{8'h09, 2'h2, 18'h1ABCD, 8'hC3, 3}, '{8'h09, 2'h3, 18'h31234, 8'h96, 3}, '{8'h0D, 2'h2, 18'h0F00F, 8'hFF, 4},
    '{8'h09, 2'h1, 18'h00000, 8'hFF, 3}, '{8'h09, 2'h3, 18'h30000, 8'h00, 3}};

  boundary_scan_test_operations u_boundary_scan_test_operations (.clk_sys(clk_sys), .reset_n(reset_n),
    .tck(tck), .tap_reset(tap_reset), .ir_code(ir_code), .capture_dr(capture_dr), .shift_dr(shift_dr),
    .update_dr(update_dr), .run_idle(run_idle), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .pin_oe_n(pin_oe_n), .core_y(core_y), .core_a(core_a), .pin_y(pin_y), .pin_y_oe(pin_y_oe),
    .sys_test_mode(sys_test_mode), .sys_run_active(sys_run_active), .sys_op(sys_op));
  scan_host u_scan_host (.tck(tck), .tdo(tdo), .tap_reset(tap_reset), .ir_code(ir_code),
    .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr), .run_idle(run_idle), .tdi(tdi));

  function automatic logic [7:0] l8(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Reference of the shift stages after a run; the enable cells never move.
  function automatic logic [17:0] model(row_t r);
    logic [15:0] v;
    v = r.seed[15:0];
    repeat (r.n) begin
      if (r.ir == 8'h0D)
        v[7:0] = ~v[7:0];
      else case (r.op)
        2'h0: v = {r.pins, ~v[7:0]};
        2'h1: v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        2'h2: v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]} ^ {r.pins, 8'h00};
        default: v = {l8(v[15:8]) ^ r.pins, l8(v[7:0])};
      endcase
    end
    return {r.seed[17:16], v};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Two unrelated clocks; the offset keeps their edges from lining up.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    tck = 1'b0;
    #3;
    forever #7.5 tck = ~tck;
  end
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end

  initial begin
    {reset_n, pin_in, pin_oe_n, core_y, mismatches, samples_checked} = {1'b0, 8'h00, 2'h1, 8'hA5, 64'h0};
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    u_scan_host.reset_tap();
    foreach (rows[i]) begin
      @(posedge tck);
      pin_in <= rows[i].pins;
      u_scan_host.scan(8'h0E, 2, {16'h0000, rows[i].op}, d);
      u_scan_host.scan(8'h0B, 18, rows[i].seed, d);
      u_scan_host.run(rows[i].ir, rows[i].n);
      want = model(rows[i]);
      `CHK("pin_y", (rows[i].ir == 8'h09 && rows[i].op == 2'h2) ? rows[i].seed[7:0] : want[7:0], pin_y)
      `CHK("core_a", (rows[i].ir == 8'h0D) ? rows[i].seed[15:8] : want[15:8], core_a)
      repeat (6) @(posedge clk_sys);
      `CHK("sys_test_mode", 1'b1, sys_test_mode)
      `CHK("sys_op", rows[i].op, sys_op)
      u_scan_host.scan(8'h0B, 18, 18'h00000, d);
      `CHK("chain", want, d)
      $display("row %0d done", i);
    end
    // Both run instructions must show a zero first out of the bypass stage.
    for (int k = 0; k < 2; k++) begin
      u_scan_host.scan(k ? 8'h0D : 8'h09, 1, 18'h00001, d);
      `CHK("bypass", 1'b0, d[0])
    end
    u_scan_host.scan(8'h0A, 18, 18'h2C3A5, d);
    u_scan_host.scan(8'h0A, 18, 18'h1F0F0, d);
    `CHK("read", 18'h2C3A5, d)
    u_scan_host.scan(8'h0C, 18, 18'h00000, d);
    `CHK("self_check", ~18'h1F0F0, d)
    @(posedge tck);
    core_y <= 8'h5A;
    @(posedge tck);
    @(negedge tck);
    `CHK("pin_y normal", 8'h5A, pin_y)
    // A long toggle run must show up as active on the system side while it lasts.
    fork
      u_scan_host.run(8'h0D, 12);
      begin
        repeat (8) @(posedge clk_sys);
        `CHK("sys_run_active", 1'b1, sys_run_active)
      end
    join
    $display("scan tests done");
    // A fresh test reset must bring back signature mode, and a control scan keeps its bits.
    u_scan_host.reset_tap();
    u_scan_host.scan(8'h0E, 2, 18'h00001, d);
    `CHK("ctrl reset", 2'h2, d[1:0])
    u_scan_host.scan(8'h0F, 2, 18'h00003, d);
    `CHK("ctrl kept", 2'h1, d[1:0])
    repeat (6) @(posedge clk_sys);
    `CHK("sys_op", 2'h3, sys_op)
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("sys status", 4'h0, {sys_test_mode, sys_run_active, sys_op})
    reset_n <= 1'b1;
    $display("reset tests done");
    give_verdict();
  end
endmodule // boundary_scan_test_operations_tb
